// File: src/acc_calib_top.sv
// Summary of operation
// - subtract stored offset from every result
// - multiply each result by stored gain factor
// - gain scales the offset-corrected value
// - per-channel phase field shifts sample instant
// - gain is 24 bits, low byte reads zero
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "acc_params.svh"

module acc_calib_top
  import acc_pkg::*;
#(
  parameter int PERIOD_CYC = `ACC_PERIOD_DEF
) (
  input wire logic mclk,
  input wire logic rst,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // synchronisation strobe pin, asynchronous to mclk
  input wire logic sync_reset_pin,
  // modulator results, same clock domain
  input wire acc_sample_t raw_ch0,
  input wire acc_sample_t raw_ch1,
  // corrected results
  output acc_sample_t corr_ch0,
  output logic corr_valid_ch0,
  output acc_sample_t corr_ch1,
  output logic corr_valid_ch1,
  output logic period_start
);

  localparam int NCH = `ACC_NCH;
  localparam int PCW = $clog2(PERIOD_CYC);

  // the phase field must address a point inside one sample period
  initial begin
    if (PERIOD_CYC < (1 << `ACC_PHASE_W) || PERIOD_CYC > (1 << 20)) begin
      $error("PERIOD_CYC must lie between 2**PHASE_W and 2**20");
    end
  end

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  // maps a byte address to its target; channel taken from the stride bit
  function automatic acc_sel_e decode(input logic [7:0] a);
    logic [7:0] loc;
    loc = a & `ACC_LOCAL_MASK;
    decode = ACC_SEL_NONE;
    if (a == `ACC_REG_STATUS) begin
      decode = ACC_SEL_STATUS;
    end else if (a < `ACC_CH_REGION_END) begin
      case (loc)
        `ACC_REG_CFG: decode = ACC_SEL_CFG;
        `ACC_REG_OFS_HI: decode = ACC_SEL_OFS_HI;
        `ACC_REG_OFS_LO: decode = ACC_SEL_OFS_LO;
        `ACC_REG_GAIN_HI: decode = ACC_SEL_GAIN_HI;
        `ACC_REG_GAIN_LO: decode = ACC_SEL_GAIN_LO;
        `ACC_REG_RESULT: decode = ACC_SEL_RESULT;
        default: decode = ACC_SEL_NONE;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // calibration storage
  // ----------------------------------------------------------------
  logic [15:0] ofs_hi [NCH]; // offset bits 23:8
  logic [7:0] ofs_lo [NCH]; // offset bits 7:0
  logic [15:0] gain_hi [NCH]; // gain bits 23:8
  logic [7:0] gain_lo [NCH]; // gain bits 7:0, no storage for the reserved byte
  logic [`ACC_PHASE_W-1:0] phase [NCH]; // capture point within the period
  acc_sample_t corr [NCH]; // corrected results
  logic corr_v [NCH];
  acc_sample_t raw [NCH];
  logic sync_seen; // a sync strobe has aligned the period since reset

  assign raw[0] = raw_ch0;
  assign raw[1] = raw_ch1;

  // ----------------------------------------------------------------
  // axi write channel
  // ----------------------------------------------------------------
  logic aw_held; // address taken, waiting for data or response
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  acc_sel_e wsel;
  logic wch;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wsel = decode(aw_addr);
  assign wch = aw_addr[`ACC_CH_STRIDE_BIT];

  // address and data are taken in either order and held until the write
  always_ff @(posedge mclk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // response follows the write one cycle later; unmapped gets slverr
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ACC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wsel == ACC_SEL_NONE || wsel == ACC_SEL_RESULT ||
                      wsel == ACC_SEL_STATUS) ? `ACC_RESP_SLVERR : `ACC_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // register update; byte strobes pick the lanes of each 16-bit field.
  // the host is expected to load the reciprocal of its measured gain
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int c = 0; c < NCH; c++) begin
        ofs_hi[c] <= `ACC_OFS_HI_RST;
        ofs_lo[c] <= `ACC_OFS_LO_RST;
        gain_hi[c] <= `ACC_GAIN_HI_RST;
        gain_lo[c] <= `ACC_GAIN_LO_RST;
        phase[c] <= `ACC_PHASE_RST;
      end
    end else if (do_write) begin
      case (wsel)
        ACC_SEL_CFG: begin
          if (w_strb[0]) phase[wch][7:0] <= w_data[7:0];
          if (w_strb[1]) phase[wch][`ACC_PHASE_W-1:8] <= w_data[`ACC_PHASE_W-1:8];
        end
        ACC_SEL_OFS_HI: begin
          if (w_strb[0]) ofs_hi[wch][7:0] <= w_data[7:0];
          if (w_strb[1]) ofs_hi[wch][15:8] <= w_data[15:8];
        end
        ACC_SEL_OFS_LO: begin
          if (w_strb[1]) ofs_lo[wch] <= w_data[15:8];
        end
        ACC_SEL_GAIN_HI: begin
          if (w_strb[0]) gain_hi[wch][7:0] <= w_data[7:0];
          if (w_strb[1]) gain_hi[wch][15:8] <= w_data[15:8];
        end
        ACC_SEL_GAIN_LO: begin
          if (w_strb[1]) gain_lo[wch] <= w_data[15:8];
        end
        default: begin
          // read-only and unmapped targets keep their contents
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------
  acc_sel_e rsel;
  logic rch;
  logic rd_gain_lo; // helper: last read targeted a gain low register

  assign s_axi_arready = !s_axi_rvalid;
  assign rsel = decode(s_axi_araddr);
  assign rch = s_axi_araddr[`ACC_CH_STRIDE_BIT];

  // data is ready one cycle after the address is taken
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `ACC_RESP_OKAY;
      rd_gain_lo <= 1'b0;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `ACC_RESP_OKAY;
      rd_gain_lo <= (rsel == ACC_SEL_GAIN_LO);
      case (rsel)
        ACC_SEL_CFG: s_axi_rdata <= {22'h0, phase[rch]};
        ACC_SEL_OFS_HI: s_axi_rdata <= {16'h0, ofs_hi[rch]};
        ACC_SEL_OFS_LO: s_axi_rdata <= {16'h0, ofs_lo[rch], `ACC_LO_RSVD};
        ACC_SEL_GAIN_HI: s_axi_rdata <= {16'h0, gain_hi[rch]};
        ACC_SEL_GAIN_LO: s_axi_rdata <= {16'h0, gain_lo[rch], `ACC_LO_RSVD};
        ACC_SEL_RESULT: s_axi_rdata <= {8'h0, corr[rch]};
        ACC_SEL_STATUS: s_axi_rdata <= {31'h0, sync_seen};
        default: begin
          // unmapped address: zero data, slave error
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `ACC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // sample period and synchronisation
  // ----------------------------------------------------------------
  logic sync_ff1; // first synchroniser stage, read only by sync_ff2
  logic sync_ff2;
  logic sync_ff3; // previous level, for the edge
  logic sync_edge;
  logic [PCW-1:0] period_cnt; // position inside the sample period

  assign sync_edge = sync_ff2 && !sync_ff3;
  assign period_start = (period_cnt == '0);

  // the pin is asynchronous, so it passes two flops before use
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync_ff1 <= 1'b0;
      sync_ff2 <= 1'b0;
      sync_ff3 <= 1'b0;
    end else begin
      sync_ff1 <= sync_reset_pin;
      sync_ff2 <= sync_ff1;
      sync_ff3 <= sync_ff2;
    end
  end

  // a strobe restarts the period; devices strobed together stay aligned
  always_ff @(posedge mclk) begin
    if (rst) begin
      period_cnt <= '0;
      sync_seen <= 1'b0;
    end else begin
      if (sync_edge || period_cnt == PCW'(PERIOD_CYC - 1)) begin
        period_cnt <= '0;
      end else begin
        period_cnt <= period_cnt + PCW'(1);
      end
      if (sync_edge) begin
        sync_seen <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // per-channel phase capture and correction
  // ----------------------------------------------------------------
  // a channel with phase zero is the reference; others sample later
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic cap_valid;
    acc_sample_t cap;

    always_ff @(posedge mclk) begin
      if (rst) begin
        cap_valid <= 1'b0;
        cap <= 24'sh0;
      end else begin
        cap_valid <= (period_cnt == PCW'(phase[c]));
        if (period_cnt == PCW'(phase[c])) begin
          cap <= raw[c];
        end
      end
    end

    acc_corrector u_corr (
      .mclk(mclk),
      .rst(rst),
      .in_valid(cap_valid),
      .raw(cap),
      .offset({ofs_hi[c], ofs_lo[c]}),
      .gain({gain_hi[c], gain_lo[c]}),
      .out_valid(corr_v[c]),
      .result(corr[c])
    );

    a_phase_capture: assert property (@(posedge mclk) disable iff (rst)
      cap_valid |-> $past(period_cnt) == PCW'($past(phase[c])))
      else $error("capture not at the programmed phase");
  end

  assign corr_ch0 = corr[0];
  assign corr_valid_ch0 = corr_v[0];
  assign corr_ch1 = corr[1];
  assign corr_valid_ch1 = corr_v[1];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_capture0;
    g_ch[0].cap_valid;
  endsequence

  sequence s_result0;
    ##2 corr_v[0];
  endsequence

  a_result_follows: assert property (@(posedge mclk) disable iff (rst)
    s_capture0 |-> s_result0)
    else $error("corrected result did not follow capture");

  a_gain_lo_zero: assert property (@(posedge mclk) disable iff (rst)
    (s_axi_rvalid && rd_gain_lo) |-> s_axi_rdata[7:0] == `ACC_LO_RSVD)
    else $error("reserved gain byte read nonzero");

  a_sync_restart: assert property (@(posedge mclk) disable iff (rst)
    sync_edge |=> period_cnt == '0)
    else $error("sync strobe did not restart the period");

endmodule
`default_nettype wire

// File: src/acc_params.svh
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// ----------------------------------------------------------------
// widths and counts
// ----------------------------------------------------------------
`define ACC_NCH 2
`define ACC_SAMPLE_W 24
`define ACC_PHASE_W 10
`define ACC_PERIOD_DEF 1024
`define ACC_UNITY_SHIFT 23
`define ACC_ADDR_W 8

// ----------------------------------------------------------------
// register map, byte addresses
// ----------------------------------------------------------------
`define ACC_CH_STRIDE_BIT 5
`define ACC_CH_REGION_END 8'h40
`define ACC_LOCAL_MASK 8'h1f
`define ACC_REG_CFG 8'h00
`define ACC_REG_OFS_HI 8'h04
`define ACC_REG_OFS_LO 8'h08
`define ACC_REG_GAIN_HI 8'h0c
`define ACC_REG_GAIN_LO 8'h10
`define ACC_REG_RESULT 8'h14
`define ACC_REG_STATUS 8'h40

// ----------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------
`define ACC_GAIN_HI_RST 16'h8000
`define ACC_GAIN_LO_RST 8'h00
`define ACC_OFS_HI_RST 16'h0000
`define ACC_OFS_LO_RST 8'h00
`define ACC_PHASE_RST 10'h000
`define ACC_LO_RSVD 8'h00
`define ACC_SAT_MAX 24'h7fffff
`define ACC_SAT_MIN 24'h800000
`define ACC_RESP_OKAY 2'h0
`define ACC_RESP_SLVERR 2'h2

`endif

// File: src/acc_pkg.sv
`default_nettype none
package acc_pkg;
  // one corrected or raw conversion result
  typedef logic signed [23:0] acc_sample_t;
  // decoded register target
  typedef enum {
    ACC_SEL_CFG,
    ACC_SEL_OFS_HI,
    ACC_SEL_OFS_LO,
    ACC_SEL_GAIN_HI,
    ACC_SEL_GAIN_LO,
    ACC_SEL_RESULT,
    ACC_SEL_STATUS,
    ACC_SEL_NONE
  } acc_sel_e;
endpackage
`default_nettype wire

// File: src/acc_corrector.sv
`timescale 1ns/1ps
`default_nettype none
`include "acc_params.svh"

module acc_corrector
  import acc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic in_valid,
  input wire acc_sample_t raw,
  input wire acc_sample_t offset,
  input wire logic [23:0] gain,
  output logic out_valid,
  output acc_sample_t result
);

  // ----------------------------------------------------------------
  // saturating scale
  // ----------------------------------------------------------------
  // product scaled by unity and clipped to the output range
  function automatic acc_sample_t scale_sat(input logic signed [49:0] p);
    logic signed [49:0] s;
    s = p >>> `ACC_UNITY_SHIFT;
    if (s > $signed({26'h0, `ACC_SAT_MAX})) begin
      scale_sat = `ACC_SAT_MAX;
    end else if (s < $signed({{26{1'b1}}, `ACC_SAT_MIN})) begin
      scale_sat = `ACC_SAT_MIN;
    end else begin
      scale_sat = s[23:0];
    end
  endfunction

  logic signed [24:0] diff; // offset-corrected value, one bit of headroom
  logic v1; // diff holds a fresh value
  logic signed [49:0] prod; // gain stays unsigned, so a zero is prepended

  assign prod = diff * $signed({1'b0, gain});

  // ----------------------------------------------------------------
  // stage one: offset
  // ----------------------------------------------------------------
  // subtract first so that the gain scales the offset-free value
  always_ff @(posedge mclk) begin
    if (rst) begin
      diff <= 25'sh0;
      v1 <= 1'b0;
    end else begin
      v1 <= in_valid;
      if (in_valid) begin
        diff <= {raw[23], raw} - {offset[23], offset};
      end
    end
  end

  // ----------------------------------------------------------------
  // stage two: gain and saturation
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      result <= 24'sh0;
      out_valid <= 1'b0;
    end else begin
      out_valid <= v1;
      if (v1) begin
        result <= scale_sat(prod);
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_offset_subtract: assert property (@(posedge mclk) disable iff (rst)
    in_valid |=> diff == {$past(raw[23]), $past(raw)} - {$past(offset[23]), $past(offset)})
    else $error("offset not subtracted from sample");

  a_gain_after_ofs: assert property (@(posedge mclk) disable iff (rst)
    v1 |=> out_valid && result == scale_sat($past(diff) * $signed({1'b0, $past(gain)})))
    else $error("gain not applied to offset-corrected value");

  a_unity_passes: assert property (@(posedge mclk) disable iff (rst)
    (v1 && gain == {`ACC_GAIN_HI_RST, `ACC_GAIN_LO_RST} && diff[24] == diff[23])
    |=> result == $past(diff[23:0]))
    else $error("unity gain altered the sample");

endmodule
`default_nettype wire

// File: test/acc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// host model: register bus master and sync strobe
// ----------------------------------------
module acc_host_model (
  input wire logic mclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready,
  output logic sync_pin
);
  int tmo = 0; // bus waits that ran out
  int ref_ch = 0; // channel kept at phase zero for the group
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, sync_pin} = '0;
  end
  // reciprocal of a measured gain, unity at 2^23, clipped to the field
  function automatic logic [23:0] inv_gain(input logic [23:0] m);
    logic [47:0] q;
    q = 48'h400000000000 / {24'h0, m};
    return (q > 48'hffffff) ? 24'hffffff : q[23:0];
  endfunction
  // handshakes are looked at mid-cycle, so the release edge never races
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    int n;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(negedge mclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge mclk);
      if (ta) begin
        awvalid <= 1'b0;
        awaddr <= ~a; // released lines show no stale value
      end
      if (tw) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (tb) begin
        bready <= 1'b0;
        break;
      end
    end
    if (n == 200) tmo++;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    int n;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(negedge mclk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge mclk);
      if (ta) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (tr) begin
        rready <= 1'b0;
        break;
      end
    end
    if (n == 200) tmo++;
  endtask
  // one strobe, the same edge any group member would see
  task automatic strobe();
    @(posedge mclk);
    sync_pin <= 1'b1;
    repeat (6) @(posedge mclk);
    sync_pin <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: test/adc_sample_calibration_correction_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module adc_sample_calibration_correction_tb;
  import acc_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sync_pin, v0, v1, pstart;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r2;
  acc_sample_t raw0 = '0;
  acc_sample_t raw1 = '0;
  acc_sample_t c0, c1, r0, o0, r1, o1;
  logic [23:0] g0, g1;
  logic [9:0] ph;
  logic [31:0] seed = 32'h766fd7ba;
  int n;
  int err_count = 0;
  int cmp_count = 0;
  always #2.5 mclk = ~mclk;
  acc_calib_top #(.PERIOD_CYC(1024)) u_dut (
    .mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sync_reset_pin(sync_pin), .raw_ch0(raw0), .raw_ch1(raw1), .corr_ch0(c0),
    .corr_valid_ch0(v0), .corr_ch1(c1), .corr_valid_ch1(v1), .period_start(pstart));
  acc_host_model u_host (
    .mclk(mclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .sync_pin(sync_pin));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // offset first, then gain with 2^23 as unity, then clip to 24 bits
  function automatic acc_sample_t model(input acc_sample_t r, input acc_sample_t o,
                                        input logic [23:0] g);
    longint p;
    p = (longint'(r) - longint'(o)) * longint'({40'h0, g});
    p = p >>> 23;
    if (p > 64'sd8388607) return 24'h7fffff;
    if (p < -64'sd8388608) return 24'h800000;
    return p[23:0];
  endfunction
  task automatic end_of_test();
    err_count += u_host.tmo;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // a bus wait that ran out ends the run at once
  always @(u_host.tmo) if (u_host.tmo != 0) end_of_test();
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask
  task automatic wok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    u_host.wr(a, d, r);
    `CHK("wr_resp", 2'h0, r)
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] dd;
    logic [1:0] r;
    u_host.rd(a, dd, r);
    `CHK(nm, {2'h0, e}, {r, dd})
  endtask
  // offset and gain split over high and low halves
  task automatic cal(input int c, input acc_sample_t o, input logic [23:0] g);
    logic [7:0] b;
    b = 8'(c * 32);
    wok(b + 8'h04, {16'h0, o[23:8]});
    wok(b + 8'h08, {16'h0, o[7:0], 8'h00});
    wok(b + 8'h0c, {16'h0, g[23:8]});
    wok(b + 8'h10, {16'h0, g[7:0], 8'h00});
  endtask
  task automatic wait_v0();
    for (n = 0; n < 2200; n++) begin
      @(negedge mclk);
      if (v0 === 1'b1) break;
    end
    if (n == 2200) begin
      err_count++;
      end_of_test();
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    for (int c = 0; c < 2; c++) begin
      for (int r = 0; r < 5; r++) begin
        rchk("reset", 8'(c * 32 + r * 4), (r == 3) ? 32'h8000 : 32'h0);
      end
    end
    rchk("status", 8'h40, 32'h0);
    done("reset");
    wok(8'h10, 32'hffffffff);
    rchk("gain_lo", 8'h10, 32'h0000ff00);
    u_host.wr(8'h14, 32'h1234, r2);
    `CHK("ro_wr", 2'h2, r2)
    u_host.wr(8'h40, 32'h1, r2);
    `CHK("st_wr", 2'h2, r2)
    u_host.rd(8'h3c, d, r2);
    `CHK("unmap_rd", 34'h200000000, {r2, d})
    done("access");
    for (int i = 0; i < 10; i++) begin
      r0 = 24'(xs());
      o0 = 24'(xs());
      g0 = 24'(xs());
      r1 = 24'(xs());
      o1 = 24'(xs());
      g1 = 24'(xs());
      case (i)
        0: {r0, o0, g0} = {24'h7fffff, 24'h800000, 24'hffffff}; // top clip
        1: {r0, o0, g0} = {24'h800000, 24'h7fffff, 24'hffffff}; // bottom clip
        2: {r0, o0, g0} = {24'h100100, 24'h000100, u_host.inv_gain(24'ha00000)};
        3: {o0, g0} = {24'h0, 24'h800000}; // unity passes raw through
        default: o0 = o0 >>> 6; // keep some results inside the range
      endcase
      cal(0, o0, g0);
      cal(1, o1, g1);
      @(posedge mclk);
      raw0 <= r0;
      raw1 <= r1;
      wait_v0(); // first result may predate the new settings
      wait_v0();
      `CHK("ch0", model(r0, o0, g0), c0)
      `CHK("ch1", model(r1, o1, g1), c1)
      `CHK("same_phase", 1'b1, v1)
    end
    rchk("result", 8'h14, {8'h0, model(r0, o0, g0)});
    done("correction");
    for (int k = 0; k < 2; k++) begin
      ph = k ? 10'h3ff : 10'(1 + xs() % 1000);
      wok(8'((1 - u_host.ref_ch) * 32), {22'h0, ph});
      rchk("cfg", 8'h20, {22'h0, ph});
      wait_v0();
      wait_v0();
      for (n = 1; n < 1100; n++) begin
        @(negedge mclk);
        if (v1 === 1'b1) break;
      end
      `CHK("phase", 32'(ph), n)
    end
    done("phase");
    wait_v0();
    fork
      u_host.strobe();
      begin
        @(posedge mclk);
        for (n = 0; n < 9; n++) begin
          @(negedge mclk);
          if (pstart === 1'b1) break;
        end
      end
    join
    `CHK("sync", 1'b1, n >= 3 && n <= 4)
    rchk("status", 8'h40, 32'h1);
    done("sync");
    end_of_test();
  end
endmodule
`default_nettype wire
